// File: logic/bms_pkg.sv
package bms_pkg;
  // Byte address at which the boot mode register appears in emulation mode.
  localparam logic [31:0] BMS_MODE_REG_ADDR = 32'h0000_07FD;
  // Mode-select pin codes.
  localparam logic [2:0] BMS_PINS_EXT_VECTOR = 3'h1;
  localparam logic [2:0] BMS_PINS_USER_TEST = 3'h2;
  // Reserved code that halts the core without raising the core-test pin.
  localparam logic [2:0] BMS_PINS_HALT_ONLY = 3'h0;
  // Field layout of the boot mode register.
  localparam int BMS_WIDTH_LSB = 0;
  localparam int BMS_WIDTH_MSB = 1;
  localparam logic [7:0] BMS_MODE_RESET = 8'h00;
  localparam logic [7:0] BMS_RESERVED_MASK = 8'hFC;
  // Bus-width field codes.
  localparam logic [1:0] BMS_WIDTH_8 = 2'h0;
  localparam logic [1:0] BMS_WIDTH_16 = 2'h1;
  localparam logic [1:0] BMS_WIDTH_32 = 2'h2;
  localparam logic [1:0] BMS_WIDTH_OFF = 2'h3;
  // Boot sequencer states, one-hot.
  typedef enum logic [5:0] {
    BMS_ST_RESET = 6'h01,
    BMS_ST_FETCH = 6'h02,
    BMS_ST_WAIT = 6'h04,
    BMS_ST_RUN = 6'h08,
    BMS_ST_USER_TEST = 6'h10,
    BMS_ST_HALT = 6'h20
  } bms_state_t;
endpackage

// File: logic/bms_boot_mode_select.sv
// Contract
// - Pins 001 fetch the mode vector externally; width comes from fetched data.
// - Pins 010 set the user-test flag and enter user circuit test mode.
// - In user test the core is suspended; clocks keep running.
// - Codes 000 and 011 to 111 are reserved; they include core test mode.
// - Core test mode drives the core-test pin high; board routes core pins.
// - The register is loaded by hardware fetch; core runs in that mode.
// - Only a full system reset cause or an emulator write in RUN loads the boot mode register.
// - User program accesses never reach the boot mode register.
// - In emulation mode the register is mapped at byte address 0000_07FD.
// - Width field bits 1..0 select 8, 16 or 32 bit bus.
// - The loaded width field is copied into area zero data-width bits.
// - Only external-ROM, external-bus mode is provided.
// - Bus width is set by the boot field and per-area width bits.
`timescale 1ns/1ps
`default_nettype none
module bms_boot_mode_select
  import bms_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic init_reset_i,
  input wire logic mode_select_pin_2_i,
  input wire logic mode_select_pin_1_i,
  input wire logic mode_select_pin_0_i,
  output logic vector_fetch_req_o,
  input wire logic vector_fetch_ack_i,
  input wire logic [7:0] vector_fetch_data_i,
  input wire logic emulation_mode_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  output logic [7:0] bus_rdata_o,
  output logic bus_hit_o,
  output logic [7:0] boot_mode_register_o,
  output logic [1:0] area_config_zero_width_o,
  output logic area_config_zero_load_o,
  output logic user_test_flag_o,
  output logic core_test_pin_o,
  output logic core_run_o,
  output logic mode_invalid_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  //
  // Two groups of state live here. The sequencer, the read data, the load pulse
  // and the status flags follow rst_i. The mode data, the captured strapping code
  // and the fresh marker do not: they belong to the full system reset alone, so a
  // lighter reset can restart the core without fetching the mode vector again.

  bms_state_t state, next_state;
  logic [2:0] pins, next_pins;
  logic [7:0] boot_mode_register, next_boot_mode_register;
  logic [7:0] rdata, next_rdata;
  logic load_pulse, next_load_pulse;
  logic fresh, next_fresh;
  logic user_test, next_user_test;
  logic core_test, next_core_test;
  logic core_run, next_core_run;
  logic invalid, next_invalid;
  logic reg_hit;

  // The register answers the bus only while an emulator holds the core.
  // Outside emulation mode the decode is forced low, so user code never sees it.
  assign reg_hit = emulation_mode_i && (bus_addr_i == BMS_MODE_REG_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic. A full system reset is the only path that samples the
  // pins and fetches, so lighter resets leave the mode data untouched.
  //
  // The fresh marker tells the two exits from RESET apart. Set while the full
  // reset cause is present, it sends the sequencer through the vector fetch on code 001;
  // cleared, it sends it straight back to the mode that was chosen before.

  always_comb begin
    next_state = state;
    next_pins = pins;
    next_boot_mode_register = boot_mode_register;
    next_load_pulse = 1'b0;
    next_rdata = rdata;
    next_fresh = fresh;
    case (state)
      BMS_ST_RESET: begin
        if (!init_reset_i) begin
          next_fresh = 1'b0;
          if (fresh) begin
            // A full reset has just ended: decode the code it captured.
            if (pins == BMS_PINS_EXT_VECTOR) begin
              next_state = BMS_ST_FETCH;
            end else if (pins == BMS_PINS_USER_TEST) begin
              next_state = BMS_ST_USER_TEST;
            end else begin
              next_state = BMS_ST_HALT;
            end
          end else begin
            // A lighter reset resumes the chosen mode; the mode data is kept.
            if (pins == BMS_PINS_EXT_VECTOR) begin
              next_state = BMS_ST_WAIT;
            end else if (pins == BMS_PINS_USER_TEST) begin
              next_state = BMS_ST_USER_TEST;
            end else begin
              next_state = BMS_ST_HALT;
            end
          end
        end
      end
      BMS_ST_FETCH: begin
        // The core stays stopped until the mode data has been taken.
        if (vector_fetch_ack_i) begin
          next_boot_mode_register = vector_fetch_data_i;
          next_load_pulse = 1'b1;
          next_state = BMS_ST_WAIT;
        end
      end
      BMS_ST_WAIT: begin
        // One settling cycle lets area zero take the new width before the core runs.
        next_state = BMS_ST_RUN;
      end
      BMS_ST_RUN: begin
        // Emulator writes land here only; outside RUN a write to the decoded address is ignored.
        if (reg_hit && bus_wr_i) begin
          next_boot_mode_register = bus_wdata_i;
          next_load_pulse = 1'b1;
        end
      end
      BMS_ST_USER_TEST: begin
        next_state = BMS_ST_USER_TEST;
      end
      BMS_ST_HALT: begin
        next_state = BMS_ST_HALT;
      end
      default: begin
        next_state = BMS_ST_RESET;
      end
    endcase
    // Reads return the value held at the start of the access.
    if (reg_hit && bus_rd_i) begin
      next_rdata = boot_mode_register;
    end
    // The full reset cause overrides the next state and keeps sampling the pins; a fetch or write in that cycle still loads the register.
    if (init_reset_i) begin
      next_state = BMS_ST_RESET;
      next_pins = {mode_select_pin_2_i, mode_select_pin_1_i, mode_select_pin_0_i};
      next_fresh = 1'b1;
    end
  end

  // Registers that follow rst_i.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= BMS_ST_RESET;
      load_pulse <= 1'b0;
      rdata <= BMS_MODE_RESET;
    end else begin
      state <= next_state;
      load_pulse <= next_load_pulse;
      rdata <= next_rdata;
    end
  end

  // Kept out of rst_i on purpose: only the full reset fetch and emulator writes rewrite the mode
  // data. The price is an unknown value until the first vector fetch has ended,
  // so the full reset cause must be given once after power-up.
  always_ff @(posedge clk_i) begin
    boot_mode_register <= next_boot_mode_register;
    pins <= next_pins;
    fresh <= next_fresh;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags. Each is the decode of the next state, registered, so that it
  // comes from a flip-flop yet changes on the same edge as the state itself.
  // Decoding the next values rather than the current ones costs one layer of
  // logic in front of the flops and saves a cycle of lag on every flag.

  always_comb begin
    next_user_test = (next_state == BMS_ST_USER_TEST);
    next_core_test = (next_state == BMS_ST_HALT) && (next_pins != BMS_PINS_HALT_ONLY);
    next_core_run = (next_state == BMS_ST_RUN);
    next_invalid = (next_state == BMS_ST_RUN) &&
      (((next_boot_mode_register & BMS_RESERVED_MASK) != BMS_MODE_RESET) ||
      (next_boot_mode_register[BMS_WIDTH_MSB:BMS_WIDTH_LSB] == BMS_WIDTH_OFF));
  end

  // Status registers; rst_i clears them, as RESET decodes to all low.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      user_test <= 1'b0;
      core_test <= 1'b0;
      core_run <= 1'b0;
      invalid <= 1'b0;
    end else begin
      user_test <= next_user_test;
      core_test <= next_core_test;
      core_run <= next_core_run;
      invalid <= next_invalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs. The area zero width is a plain slice of the mode data, so the
  // area configuration logic sees a new width on the same edge as the load pulse.
  // The checks on reserved bits and width code 11 only flag the fault; the
  // register keeps whatever the supplier gave, as the bus has no way to refuse it.

  assign vector_fetch_req_o = (state == BMS_ST_FETCH);
  assign bus_hit_o = reg_hit;
  assign bus_rdata_o = rdata;
  assign boot_mode_register_o = boot_mode_register;
  assign area_config_zero_width_o = boot_mode_register[BMS_WIDTH_MSB:BMS_WIDTH_LSB];
  assign area_config_zero_load_o = load_pulse;
  assign user_test_flag_o = user_test;
  // Core test is entered by a reserved code other than all zeros.
  assign core_test_pin_o = core_test;
  assign core_run_o = core_run;
  // Flags mode data that breaks the supplier's side of the bargain.
  assign mode_invalid_o = invalid;

endmodule
`default_nettype wire

// File: verification/bms_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bms_checker
  import bms_pkg::*;
(
  input wire logic clk_i, rst_i, init_reset_i, emulation_mode_i, bus_wr_i,
  input wire logic mode_select_pin_2_i, mode_select_pin_1_i, mode_select_pin_0_i,
  input wire logic vector_fetch_req_o, vector_fetch_ack_i, bus_hit_o, core_run_o,
  input wire logic area_config_zero_load_o, user_test_flag_o, core_test_pin_o,
  input wire logic [7:0] vector_fetch_data_i, boot_mode_register_o,
  input wire logic [31:0] bus_addr_i
);
  logic [2:0] pins;
  logic take;
  logic mapped;
  logic quiet;
  logic loaded = 1'b0;
  // Mode data is unknown until the first fetch, so the hold check waits for it.
  always @(posedge clk_i) begin
    if (take) begin
      loaded <= 1'b1;
    end
  end
  assign mapped = emulation_mode_i && (bus_addr_i == BMS_MODE_REG_ADDR);
  assign quiet = loaded && !take && !(bus_hit_o && bus_wr_i);
  // The strapping code and the moment the fetch data is taken.
  assign pins = {mode_select_pin_2_i, mode_select_pin_1_i, mode_select_pin_0_i};
  assign take = vector_fetch_req_o && vector_fetch_ack_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Leaving full reset with a strapping code inside the given range.
  sequence s_leave(logic [2:0] lo, logic [2:0] hi);
    init_reset_i ##1 !init_reset_i && pins >= lo && pins <= hi;
  endsequence
  AST_FETCH: assert property (s_leave(3'h1, 3'h1) |-> ##[1:2] vector_fetch_req_o)
    else $error("fetch not started");
  AST_UTEST: assert property (s_leave(3'h2, 3'h2) |-> ##[1:2] user_test_flag_o)
    else $error("user test not entered");
  AST_CORE: assert property (s_leave(3'h3, 3'h7) |-> ##[1:2] core_test_pin_o)
    else $error("core test pin low");
  AST_HALT: assert property (user_test_flag_o |-> !core_run_o)
    else $error("core runs in user test");
  // The fetched byte stands in the register together with the area load pulse.
  sequence s_loaded;
    boot_mode_register_o == $past(vector_fetch_data_i) && area_config_zero_load_o;
  endsequence
  AST_LOAD: assert property (take |=> s_loaded)
    else $error("mode data not loaded");
  AST_RUN: assert property (take |=> ##1 core_run_o)
    else $error("core not started");
  AST_KEEP: assert property (quiet |=> $stable(boot_mode_register_o))
    else $error("mode register changed");
  AST_HIT: assert property (bus_hit_o == mapped)
    else $error("wrong register mapping");
endmodule
bind bms_boot_mode_select bms_checker bms_checker_i (.*);
`default_nettype wire

// File: verification/bms_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
module bms_rom_model (
  input wire logic clk_i,
  input wire logic fetch_req_i,
  input wire logic [7:0] mode_data_i,
  output logic fetch_ack_o,
  output logic [7:0] fetch_data_o
);
  logic [1:0] wait_cnt = 2'h0;
  // A slow image: it answers on the fourth cycle of each request.
  always @(posedge clk_i) begin
    fetch_ack_o <= fetch_req_i && !fetch_ack_o && wait_cnt == 2'h2;
    wait_cnt <= (fetch_req_i && !fetch_ack_o) ? wait_cnt + 2'h1 : 2'h0;
  end
  // Outside the answer the data lines carry the inverse, so stale data never passes.
  assign fetch_data_o = fetch_ack_o ? mode_data_i : ~mode_data_i;
endmodule
`default_nettype wire

// File: verification/tb_bms_boot_mode_select.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bms_boot_mode_select;
  import bms_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, init_reset_i = 1'b1, emulation_mode_i = 1'b0;
  logic bus_wr_i = 1'b0, bus_rd_i = 1'b0, mode_select_pin_2_i, mode_select_pin_1_i;
  logic mode_select_pin_0_i, vector_fetch_req_o, vector_fetch_ack_i, bus_hit_o;
  logic area_config_zero_load_o, user_test_flag_o, core_test_pin_o, core_run_o, mode_invalid_o;
  logic [7:0] rom = 8'h00, bus_wdata_i = 8'h00, vector_fetch_data_i, bus_rdata_o;
  logic [7:0] boot_mode_register_o;
  logic [1:0] area_config_zero_width_o;
  logic [31:0] bus_addr_i = 32'h0000_0000;
  int n_mismatch = 0, comparisons = 0, cyc = 0;
  bms_boot_mode_select bms_boot_mode_select_i (.*);
  bms_rom_model bms_rom_model_i (.clk_i, .fetch_req_i(vector_fetch_req_o), .mode_data_i(rom),
    .fetch_ack_o(vector_fetch_ack_i), .fetch_data_o(vector_fetch_data_i));
  always #25 clk_i = ~clk_i;
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Full reset with a strapping code, then time for the fetch and the start.
  task automatic boot(logic [2:0] p, logic [7:0] d);
    {mode_select_pin_2_i, mode_select_pin_1_i, mode_select_pin_0_i} = p;
    rom = d;
    init_reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    init_reset_i = 1'b0;
    repeat (8) @(negedge clk_i);
  endtask
  task automatic bus(logic w, logic [31:0] a, logic [7:0] d);
    bus_wr_i = w;
    bus_rd_i = !w;
    bus_addr_i = a;
    bus_wdata_i = d;
    @(negedge clk_i);
    bus_wr_i = 1'b0;
    bus_rd_i = 1'b0;
    @(negedge clk_i);
  endtask
  task print_verdict;
    if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // A hang is cut short well beyond the roughly 160 cycles the run needs.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    {mode_select_pin_2_i, mode_select_pin_1_i, mode_select_pin_0_i} = 3'h0;
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    for (int c = 0; c < 8; c++) begin
      boot(3'(c), 8'h01);
      chk("user_test", 8'(user_test_flag_o), 8'(c == 2));
      chk("core_test", 8'(core_test_pin_o), 8'(c > 2));
      chk("core_run", 8'(core_run_o), 8'(c == 1));
    end
    for (int w = 0; w < 3; w++) begin
      boot(3'h1, 8'(w));
      chk("mode_reg", boot_mode_register_o, 8'(w));
      chk("area_width", 8'(area_config_zero_width_o), 8'(w));
    end
    boot(3'h1, 8'h03);
    chk("invalid", 8'(mode_invalid_o), 8'h01);
    boot(3'h1, 8'h04);
    chk("invalid", 8'(mode_invalid_o), 8'h01);
    {mode_select_pin_2_i, mode_select_pin_1_i, mode_select_pin_0_i} = 3'h2;
    rst_i = 1'b1;
    @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk("kept", boot_mode_register_o, 8'h04);
    chk("resume", 8'(core_run_o), 8'h01);
    boot(3'h1, 8'h01);
    bus(1'b1, BMS_MODE_REG_ADDR, 8'h02);
    chk("no_emulation", boot_mode_register_o, 8'h01);
    emulation_mode_i = 1'b1;
    bus(1'b1, 32'h0000_07FC, 8'h02);
    chk("other_addr", boot_mode_register_o, 8'h01);
    bus(1'b1, BMS_MODE_REG_ADDR, 8'h02);
    bus(1'b0, BMS_MODE_REG_ADDR, 8'h00);
    chk("read_back", bus_rdata_o, 8'h02);
    chk("area_width", 8'(area_config_zero_width_o), 8'h02);
    print_verdict();
  end
endmodule
`default_nettype wire
